// file: logic/trx_cfg_regs.sv
// Top of the transmitter configuration bank: serial frame control and register file.
`timescale 1ns/1ps
`default_nettype none

module trx_cfg_regs
	import trx_pkg::*;
(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic spi_cs_n,
	input wire logic spi_sclk,
	input wire logic spi_sdi,
	output logic spi_sdo,
	output logic spi_sdo_oe_n,
	input wire logic digital_lock_in,
	input wire logic vco_cal_done_in,
	output logic ext_lo_input_buffer_on,
	output logic lo_forward_buffer_on,
	output logic modulator_switch_buffer_on,
	output logic vatten_dac_on,
	output logic synth_power_on,
	output logic modulator_lo_source_sel,
	output logic [4:0] ch0_step_atten_word,
	output logic [4:0] ch1_step_atten_word,
	output logic [10:0] ch0_vatten_word,
	output logic [10:0] ch1_vatten_word,
	output logic local_osc_range_sel,
	output logic output_freq_range_sel,
	output logic dig_out_high_level,
	output logic [2:0] lock_window_sel,
	output logic [1:0] lock_pin_function_sel,
	output logic [4:0] lock_window_half_ns,
	output logic lock_detect_pin
);

	// ----------------------------------------
	// Pin synchronisation and edge detection
	// ----------------------------------------
	logic [SYNC_W-1:0] pins_sync;
	logic sclk_prev_reg;
	logic cs_prev_reg;

	trx_pin_sync u_sync (
		.mclk(mclk),
		.nrst(nrst),
		.pins({vco_cal_done_in, digital_lock_in, spi_sdi, spi_sclk, spi_cs_n}),
		.pins_sync(pins_sync)
	);

	wire logic cs_n_s = pins_sync[SY_CS_N];
	wire logic sclk_s = pins_sync[SY_SCLK];
	wire logic lock_s = pins_sync[SY_LOCK];
	wire logic cal_s = pins_sync[SY_CAL];
	wire logic sclk_rise = sclk_s && !sclk_prev_reg && !cs_n_s;
	wire logic sclk_fall = !sclk_s && sclk_prev_reg && !cs_n_s;
	wire logic cs_fall = !cs_n_s && cs_prev_reg;

	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			sclk_prev_reg <= 1'b0;
			cs_prev_reg <= 1'b1;
		end
		else
		begin
			sclk_prev_reg <= sclk_s;
			cs_prev_reg <= cs_n_s;
		end
	end

	// ----------------------------------------
	// Serial shift register
	// ----------------------------------------
	trx_shift_if sif ();

	trx_shifter u_shift (
		.mclk(mclk),
		.nrst(nrst),
		.sif(sif)
	);

	// ----------------------------------------
	// Frame state machine
	// ----------------------------------------
	// A frame is one read flag, seven address bits and eight data bits, MSB first.
	// Since the serial clock is oversampled, it must stay below a quarter of mclk.
	trx_state_t state_reg;
	trx_state_t state_next;
	logic rd_reg;
	logic [6:0] addr_reg;
	logic [NUM_REGS-1:0][7:0] regs_reg;

	wire logic cmd_done = (sif.bit_cnt == FRAME_CMD_BITS);
	wire logic frame_done = (sif.bit_cnt == FRAME_BITS);
	wire logic addr_hit = trx_mapped(addr_reg);
	wire logic [3:0] addr_idx = trx_index(addr_reg);
	wire logic [7:0] rd_data = addr_hit ? regs_reg[addr_idx] : RST_ZERO;
	wire logic wr_pulse = (state_reg == ST_DATA) && frame_done && !rd_reg;
	wire logic [7:0] wr_data = sif.shift_in[7:0] & trx_mask(addr_idx);

	assign sif.start = cs_fall;
	assign sif.sample = sclk_rise && ((state_reg == ST_CMD) || (state_reg == ST_DATA));
	assign sif.sdi_bit = pins_sync[SY_SDI];
	assign sif.load = sclk_fall && (state_reg == ST_DATA) && cmd_done;
	assign sif.load_data = rd_data;
	assign sif.shift_out = sclk_fall && (state_reg == ST_DATA) && !cmd_done;

	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE:
				if (cs_fall)
					state_next = ST_CMD;
			ST_CMD:
				if (cs_n_s)
					state_next = ST_IDLE;
				else if (cmd_done)
					state_next = ST_DATA;
			ST_DATA:
				if (cs_n_s)
					state_next = ST_IDLE;
				else if (frame_done)
					state_next = ST_HOLD;
			ST_HOLD:
				if (cs_n_s)
					state_next = ST_IDLE;
			default:
				state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (!nrst)
			state_reg <= ST_IDLE;
		else
			state_reg <= state_next;
	end

	// Command byte is latched once all eight command bits are in.
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			rd_reg <= 1'b0;
			addr_reg <= '0;
		end
		else if ((state_reg == ST_CMD) && cmd_done)
		begin
			rd_reg <= sif.shift_in[7];
			addr_reg <= sif.shift_in[6:0];
		end
	end

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	// Unused bits are never stored, so they read back as zero whatever the host wrote.
	// A frame cut short by chip select leaves every register untouched.
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			for (int i = 0; i < NUM_REGS; i++)
				regs_reg[i] <= trx_reset(4'(i));
		end
		else if (wr_pulse && addr_hit)
			regs_reg[addr_idx] <= wr_data;
	end

	// ----------------------------------------
	// Serial data out
	// ----------------------------------------
	// The output is enabled only during the data phase of a read.
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			spi_sdo <= 1'b0;
			spi_sdo_oe_n <= 1'b1;
		end
		else
		begin
			spi_sdo <= (state_reg == ST_DATA) && rd_reg && sif.sdo_bit;
			spi_sdo_oe_n <= !((state_reg == ST_DATA) && rd_reg);
		end
	end

	// ----------------------------------------
	// Switch matrix and power controls
	// ----------------------------------------
	assign ext_lo_input_buffer_on = regs_reg[IDX_LO_SWITCH][BIT_EXT_EXTERNAL_OSC_INPUT];
	assign lo_forward_buffer_on = regs_reg[IDX_LO_SWITCH][BIT_LO_FORWARD];
	assign modulator_switch_buffer_on = regs_reg[IDX_LO_SWITCH][BIT_SW_BUFFER];
	assign vatten_dac_on = regs_reg[IDX_LO_SWITCH][BIT_DAC_ON];
	assign synth_power_on = regs_reg[IDX_LO_SWITCH][BIT_SYNTH_ON];
	assign modulator_lo_source_sel = regs_reg[IDX_LO_SWITCH][BIT_LO_SOURCE];

	// ----------------------------------------
	// Attenuator words
	// ----------------------------------------
	// Step words go out unchanged: the value is the attenuation in dB.
	assign ch0_step_atten_word = regs_reg[IDX_CH0_STEP][STEP_MSB:0];
	assign ch1_step_atten_word = regs_reg[IDX_CH1_STEP][STEP_MSB:0];
	assign ch0_vatten_word = {regs_reg[IDX_CH0_VVA_HIGH][VVA_HIGH_MSB:0], regs_reg[IDX_CH0_VVA_LOW]};
	assign ch1_vatten_word = {regs_reg[IDX_CH1_VVA_HIGH][VVA_HIGH_MSB:0], regs_reg[IDX_CH1_VVA_LOW]};

	// ----------------------------------------
	// Band and output level
	// ----------------------------------------
	assign local_osc_range_sel = regs_reg[IDX_BAND][BIT_LO_RANGE];
	assign output_freq_range_sel = regs_reg[IDX_BAND][BIT_RF_RANGE];
	assign dig_out_high_level = regs_reg[IDX_DIG_LEVEL][BIT_DIG_LEVEL];

	// ----------------------------------------
	// Lock detect configuration
	// ----------------------------------------
	assign lock_window_sel = regs_reg[IDX_LOCK_CFG][LWIN_MSB:0];
	assign lock_pin_function_sel = regs_reg[IDX_LOCK_CFG][LPIN_MSB:LPIN_LSB];

	logic [4:0] lwin_next;
	logic lpin_next;

	always_comb
	begin
		case (lock_window_sel)
			3'h0: lwin_next = LWIN_11P5;
			3'h1, 3'h2: lwin_next = LWIN_6P5;
			3'h3: lwin_next = LWIN_3P0;
			3'h4, 3'h5: lwin_next = LWIN_5P0;
			default: lwin_next = LWIN_1P5;
		endcase
	end

	// Status sources arrive through the synchroniser, so the pin lags them by three cycles.
	always_comb
	begin
		case (lock_pin_function_sel)
			LPIN_DIGITAL: lpin_next = lock_s;
			LPIN_CAL_DONE: lpin_next = cal_s;
			LPIN_FORCE_LOW: lpin_next = 1'b0;
			default: lpin_next = 1'b1;
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			lock_window_half_ns <= LWIN_11P5;
			lock_detect_pin <= 1'b0;
		end
		else
		begin
			lock_window_half_ns <= lwin_next;
			lock_detect_pin <= lpin_next;
		end
	end

endmodule // trx_cfg_regs

`default_nettype wire

// file: logic/trx_pkg.sv
// Package of register map, field layout, reset values and frame constants for the transmitter config bank.
`default_nettype none

package trx_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [6:0] OFS_LO_SWITCH = 7'h1a;
	localparam logic [6:0] OFS_CH0_STEP = 7'h1b;
	localparam logic [6:0] OFS_CH1_STEP = 7'h1c;
	localparam logic [6:0] OFS_CH0_VVA_LOW = 7'h1d;
	localparam logic [6:0] OFS_CH0_VVA_HIGH = 7'h1e;
	localparam logic [6:0] OFS_CH1_VVA_LOW = 7'h1f;
	localparam logic [6:0] OFS_CH1_VVA_HIGH = 7'h20;
	localparam logic [6:0] OFS_BAND = 7'h21;
	localparam logic [6:0] OFS_DIG_LEVEL = 7'h22;
	localparam logic [6:0] OFS_LOCK_CFG = 7'h23;
	localparam int unsigned NUM_REGS = 10;

	// ----------------------------------------
	// Register indices (offset minus first offset)
	// ----------------------------------------
	localparam logic [3:0] IDX_LO_SWITCH = 4'h0;
	localparam logic [3:0] IDX_CH0_STEP = 4'h1;
	localparam logic [3:0] IDX_CH1_STEP = 4'h2;
	localparam logic [3:0] IDX_CH0_VVA_LOW = 4'h3;
	localparam logic [3:0] IDX_CH0_VVA_HIGH = 4'h4;
	localparam logic [3:0] IDX_CH1_VVA_LOW = 4'h5;
	localparam logic [3:0] IDX_CH1_VVA_HIGH = 4'h6;
	localparam logic [3:0] IDX_BAND = 4'h7;
	localparam logic [3:0] IDX_DIG_LEVEL = 4'h8;
	localparam logic [3:0] IDX_LOCK_CFG = 4'h9;

	// ----------------------------------------
	// Reset values and implemented-bit masks
	// ----------------------------------------
	localparam logic [7:0] RST_LO_SWITCH = 8'h1c;
	localparam logic [7:0] RST_STEP = 8'h00;
	localparam logic [7:0] RST_VVA_LOW = 8'hff;
	localparam logic [7:0] RST_VVA_HIGH = 8'h07;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] MASK_LO_SWITCH = 8'h3f;
	localparam logic [7:0] MASK_STEP = 8'h1f;
	localparam logic [7:0] MASK_VVA_LOW = 8'hff;
	localparam logic [7:0] MASK_VVA_HIGH = 8'h07;
	localparam logic [7:0] MASK_BAND = 8'h03;
	localparam logic [7:0] MASK_DIG_LEVEL = 8'h01;
	localparam logic [7:0] MASK_LOCK_CFG = 8'h37;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int unsigned BIT_EXT_EXTERNAL_OSC_INPUT = 0;
	localparam int unsigned BIT_LO_FORWARD = 1;
	localparam int unsigned BIT_SW_BUFFER = 2;
	localparam int unsigned BIT_DAC_ON = 3;
	localparam int unsigned BIT_SYNTH_ON = 4;
	localparam int unsigned BIT_LO_SOURCE = 5;
	localparam int unsigned BIT_LO_RANGE = 0;
	localparam int unsigned BIT_RF_RANGE = 1;
	localparam int unsigned BIT_DIG_LEVEL = 0;
	localparam int unsigned STEP_MSB = 4;
	localparam int unsigned VVA_HIGH_MSB = 2;
	localparam int unsigned LWIN_MSB = 2;
	localparam int unsigned LPIN_MSB = 5;
	localparam int unsigned LPIN_LSB = 4;

	// ----------------------------------------
	// Lock window in half nanoseconds and lock pin modes
	// ----------------------------------------
	localparam logic [4:0] LWIN_11P5 = 5'h17;
	localparam logic [4:0] LWIN_6P5 = 5'h0d;
	localparam logic [4:0] LWIN_3P0 = 5'h06;
	localparam logic [4:0] LWIN_5P0 = 5'h0a;
	localparam logic [4:0] LWIN_1P5 = 5'h03;
	localparam logic [1:0] LPIN_DIGITAL = 2'h0;
	localparam logic [1:0] LPIN_CAL_DONE = 2'h1;
	localparam logic [1:0] LPIN_FORCE_LOW = 2'h2;
	localparam logic [1:0] LPIN_FORCE_HIGH = 2'h3;

	// ----------------------------------------
	// Serial frame and synchroniser layout
	// ----------------------------------------
	localparam int unsigned CNT_W = 5;
	localparam logic [4:0] FRAME_CMD_BITS = 5'h08;
	localparam logic [4:0] FRAME_BITS = 5'h10;
	localparam int unsigned SYNC_W = 5;
	localparam int unsigned SY_CS_N = 0;
	localparam int unsigned SY_SCLK = 1;
	localparam int unsigned SY_SDI = 2;
	localparam int unsigned SY_LOCK = 3;
	localparam int unsigned SY_CAL = 4;
	localparam logic [4:0] SYNC_RST = 5'h01;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CMD = 2'b01,
		ST_DATA = 2'b11,
		ST_HOLD = 2'b10
	} trx_state_t;

	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------
	function automatic logic trx_mapped(input logic [6:0] addr);
		return (addr >= OFS_LO_SWITCH) && (addr <= OFS_LOCK_CFG);
	endfunction

	function automatic logic [3:0] trx_index(input logic [6:0] addr);
		logic [6:0] d;
		d = addr - OFS_LO_SWITCH;
		return d[3:0];
	endfunction

	function automatic logic [7:0] trx_mask(input logic [3:0] idx);
		case (idx)
			IDX_LO_SWITCH: return MASK_LO_SWITCH;
			IDX_CH0_STEP, IDX_CH1_STEP: return MASK_STEP;
			IDX_CH0_VVA_LOW, IDX_CH1_VVA_LOW: return MASK_VVA_LOW;
			IDX_CH0_VVA_HIGH, IDX_CH1_VVA_HIGH: return MASK_VVA_HIGH;
			IDX_BAND: return MASK_BAND;
			IDX_DIG_LEVEL: return MASK_DIG_LEVEL;
			IDX_LOCK_CFG: return MASK_LOCK_CFG;
			default: return RST_ZERO;
		endcase
	endfunction

	function automatic logic [7:0] trx_reset(input logic [3:0] idx);
		case (idx)
			IDX_LO_SWITCH: return RST_LO_SWITCH;
			IDX_CH0_STEP, IDX_CH1_STEP: return RST_STEP;
			IDX_CH0_VVA_LOW, IDX_CH1_VVA_LOW: return RST_VVA_LOW;
			IDX_CH0_VVA_HIGH, IDX_CH1_VVA_HIGH: return RST_VVA_HIGH;
			default: return RST_ZERO;
		endcase
	endfunction

endpackage

`default_nettype wire

// file: logic/trx_shift_if.sv
// Interface between the frame controller and the serial shift register.
`timescale 1ns/1ps
`default_nettype none

interface trx_shift_if;
	import trx_pkg::*;
	logic start;
	logic sample;
	logic sdi_bit;
	logic load;
	logic [7:0] load_data;
	logic shift_out;
	logic [CNT_W-1:0] bit_cnt;
	logic [15:0] shift_in;
	logic sdo_bit;

	modport ctl (
		output start,
		output sample,
		output sdi_bit,
		output load,
		output load_data,
		output shift_out,
		input bit_cnt,
		input shift_in,
		input sdo_bit
	);

	modport sh (
		input start,
		input sample,
		input sdi_bit,
		input load,
		input load_data,
		input shift_out,
		output bit_cnt,
		output shift_in,
		output sdo_bit
	);
endinterface

`default_nettype wire

// file: logic/trx_pin_sync.sv
// Two-stage synchroniser for the serial and status pins.
`timescale 1ns/1ps
`default_nettype none

module trx_pin_sync
	import trx_pkg::*;
(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [SYNC_W-1:0] pins,
	output logic [SYNC_W-1:0] pins_sync
);

	logic [SYNC_W-1:0] meta_reg;

	// The first stage feeds only the second one.
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			meta_reg <= SYNC_RST;
			pins_sync <= SYNC_RST;
		end
		else
		begin
			meta_reg <= pins;
			pins_sync <= meta_reg;
		end
	end

endmodule // trx_pin_sync

`default_nettype wire

// file: logic/trx_shifter.sv
// Serial shift register: collects command and data bits, shifts read data out.
`timescale 1ns/1ps
`default_nettype none

module trx_shifter
	import trx_pkg::*;
(
	input wire logic mclk,
	input wire logic nrst,
	trx_shift_if.sh sif
);

	logic [7:0] out_reg;
	logic [CNT_W-1:0] cnt_reg;
	logic [15:0] in_reg;

	assign sif.bit_cnt = cnt_reg;
	assign sif.shift_in = in_reg;
	assign sif.sdo_bit = out_reg[7];

	always_ff @(posedge mclk)
	begin
		if (!nrst || sif.start)
		begin
			cnt_reg <= '0;
			in_reg <= '0;
		end
		else if (sif.sample && (cnt_reg != FRAME_BITS))
		begin
			cnt_reg <= cnt_reg + 5'h01;
			in_reg <= {in_reg[14:0], sif.sdi_bit};
		end
	end

	// Read data leaves MSB first.
	always_ff @(posedge mclk)
	begin
		if (!nrst)
			out_reg <= '0;
		else if (sif.load)
			out_reg <= sif.load_data;
		else if (sif.shift_out)
			out_reg <= {out_reg[6:0], 1'b0};
	end

endmodule // trx_shifter

`default_nettype wire

// file: tb/trx_host_model.sv
// Host side model: drives serial frames into the configuration bank.
`timescale 1ns/1ps
`default_nettype none

module trx_host_model
(
	input wire logic mclk,
	output logic spi_cs_n,
	output logic spi_sclk,
	output logic spi_sdi,
	input wire logic spi_sdo
);
	initial
	begin
		spi_cs_n = 1'b1;
		spi_sclk = 1'b0;
		spi_sdi = 1'b0;
	end

	// ----------------------------------------
	// Frame task
	// ----------------------------------------
	// Phases are 6 and 4 cycles so a slow sampler still sees every level.
	task automatic xfer(input logic rw, input logic [6:0] a, input logic [7:0] d, input int n,
		output logic [7:0] q);
		logic [15:0] f;
		f = {rw, a, d};
		q = 8'h00;
		@(negedge mclk);
		spi_cs_n = 1'b0;
		for (int i = 0; i < n; i++)
		begin
			spi_sdi = f[15 - i];
			repeat (6) @(negedge mclk);
			if (i > 7)
				q = {q[6:0], spi_sdo};
			spi_sclk = 1'b1;
			repeat (4) @(negedge mclk);
			spi_sclk = 1'b0;
		end
		repeat (6) @(negedge mclk);
		spi_cs_n = 1'b1;
		// A released data line must not keep looking valid.
		spi_sdi = ~spi_sdi;
		repeat (4) @(negedge mclk);
	endtask
endmodule // trx_host_model

`default_nettype wire

// file: tb/trx_cfg_regs_checker.sv
// Checker of the configuration bank outputs, bound to the top module.
`timescale 1ns/1ps
`default_nettype none

module trx_cfg_regs_checker
	import trx_pkg::*;
(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic spi_cs_n,
	input wire logic spi_sdo,
	input wire logic spi_sdo_oe_n,
	input wire logic digital_lock_in,
	input wire logic vco_cal_done_in,
	input wire logic ext_lo_input_buffer_on,
	input wire logic lo_forward_buffer_on,
	input wire logic modulator_switch_buffer_on,
	input wire logic vatten_dac_on,
	input wire logic synth_power_on,
	input wire logic modulator_lo_source_sel,
	input wire logic [4:0] ch0_step_atten_word,
	input wire logic [4:0] ch1_step_atten_word,
	input wire logic [10:0] ch0_vatten_word,
	input wire logic [10:0] ch1_vatten_word,
	input wire logic local_osc_range_sel,
	input wire logic output_freq_range_sel,
	input wire logic dig_out_high_level,
	input wire logic [2:0] lock_window_sel,
	input wire logic [1:0] lock_pin_function_sel,
	input wire logic [4:0] lock_window_half_ns,
	input wire logic lock_detect_pin
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);

	function automatic logic [4:0] win(input logic [2:0] c);
		case (c)
			3'h0: return 5'h17;
			3'h1, 3'h2: return 5'h0d;
			3'h3: return 5'h06;
			3'h4, 3'h5: return 5'h0a;
			default: return 5'h03;
		endcase
	endfunction

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_window_map: assert property (lock_window_half_ns == win($past(lock_window_sel)))
		else $error("lock window width does not match code");
	a_pin_low: assert property ((lock_pin_function_sel == LPIN_FORCE_LOW) [*2] |-> !lock_detect_pin)
		else $error("lock pin not forced low");
	a_pin_high: assert property ((lock_pin_function_sel == LPIN_FORCE_HIGH) [*2] |-> lock_detect_pin)
		else $error("lock pin not forced high");
	a_pin_lock: assert property ((lock_pin_function_sel == LPIN_DIGITAL && $stable(digital_lock_in)) [*5]
		|-> lock_detect_pin == digital_lock_in) else $error("lock pin does not follow lock status");
	a_pin_cal: assert property ((lock_pin_function_sel == LPIN_CAL_DONE && $stable(vco_cal_done_in)) [*5]
		|-> lock_detect_pin == vco_cal_done_in) else $error("lock pin does not follow calibration");
	// A deselected port must never disturb the settings.
	a_hold_idle: assert property (spi_cs_n [*5] |-> $stable({ext_lo_input_buffer_on, lo_forward_buffer_on,
		modulator_switch_buffer_on, vatten_dac_on, synth_power_on, modulator_lo_source_sel, ch0_step_atten_word,
		ch1_step_atten_word, ch0_vatten_word, ch1_vatten_word, local_osc_range_sel, output_freq_range_sel,
		dig_out_high_level, lock_window_sel, lock_pin_function_sel})) else $error("setting changed while idle");
	a_reset_lo: assert property ($rose(nrst) |-> {modulator_lo_source_sel, synth_power_on, vatten_dac_on,
		modulator_switch_buffer_on, lo_forward_buffer_on, ext_lo_input_buffer_on, ch0_step_atten_word,
		ch1_step_atten_word, output_freq_range_sel, local_osc_range_sel, dig_out_high_level} == 19'h38000)
		else $error("switch, step or band output wrong after reset");
	a_reset_dac: assert property ($rose(nrst) |-> ch0_vatten_word == 11'h7ff && ch1_vatten_word == 11'h7ff)
		else $error("attenuator DAC word wrong after reset");
	// A deselected port must leave the shared data line alone.
	a_sdo_released: assert property (spi_cs_n [*5] |-> spi_sdo_oe_n && !spi_sdo)
		else $error("serial output driven while deselected");
endmodule // trx_cfg_regs_checker

bind trx_cfg_regs trx_cfg_regs_checker u_chk (.mclk, .nrst, .spi_cs_n, .spi_sdo, .spi_sdo_oe_n,
	.digital_lock_in, .vco_cal_done_in,
	.ext_lo_input_buffer_on, .lo_forward_buffer_on, .modulator_switch_buffer_on, .vatten_dac_on, .synth_power_on,
	.modulator_lo_source_sel, .ch0_step_atten_word, .ch1_step_atten_word, .ch0_vatten_word, .ch1_vatten_word,
	.local_osc_range_sel, .output_freq_range_sel, .dig_out_high_level, .lock_window_sel, .lock_pin_function_sel,
	.lock_window_half_ns, .lock_detect_pin);

`default_nettype wire

// file: tb/test_tx_lo_gain_band_config_regs.sv
// Self-checking testbench of the transmitter configuration bank.
`timescale 1ns/1ps
`default_nettype none

module test_tx_lo_gain_band_config_regs;
	import trx_pkg::*;
	logic mclk, nrst, cs_n, sclk, sdi, sdo, sdo_oe_n, lock_in, cal_in;
	logic [51:0] got_v;
	logic [31:0] seed;
	logic [7:0] sh [10];
	logic [7:0] q;
	int mismatches, check_count, cycles;
	localparam logic [7:0] MSK [10] = '{8'h3f, 8'h1f, 8'h1f, 8'hff, 8'h07, 8'hff, 8'h07, 8'h03, 8'h01, 8'h37};
	localparam logic [7:0] RSTV [10] = '{8'h1c, 8'h00, 8'h00, 8'hff, 8'h07, 8'hff, 8'h07, 8'h00, 8'h00, 8'h00};

	trx_cfg_regs u_trx_cfg_regs (.mclk(mclk), .nrst(nrst), .spi_cs_n(cs_n), .spi_sclk(sclk), .spi_sdi(sdi),
		.spi_sdo(sdo), .spi_sdo_oe_n(sdo_oe_n), .digital_lock_in(lock_in), .vco_cal_done_in(cal_in),
		.ext_lo_input_buffer_on(got_v[0]), .lo_forward_buffer_on(got_v[1]), .modulator_switch_buffer_on(got_v[2]),
		.vatten_dac_on(got_v[3]), .synth_power_on(got_v[4]), .modulator_lo_source_sel(got_v[5]),
		.ch0_step_atten_word(got_v[10:6]), .ch1_step_atten_word(got_v[15:11]), .ch0_vatten_word(got_v[26:16]),
		.ch1_vatten_word(got_v[37:27]), .local_osc_range_sel(got_v[38]), .output_freq_range_sel(got_v[39]),
		.dig_out_high_level(got_v[40]), .lock_window_sel(got_v[43:41]), .lock_pin_function_sel(got_v[45:44]),
		.lock_window_half_ns(got_v[50:46]), .lock_detect_pin(got_v[51]));
	trx_host_model u_trx_host_model (.mclk(mclk), .spi_cs_n(cs_n), .spi_sclk(sclk), .spi_sdi(sdi), .spi_sdo(sdo));

	always #25 mclk = ~mclk;

	// ----------------------------------------
	// Expectation helpers
	// ----------------------------------------
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic logic [4:0] win(input logic [2:0] c);
		case (c)
			3'h0: return LWIN_11P5;
			3'h1, 3'h2: return LWIN_6P5;
			3'h3: return LWIN_3P0;
			3'h4, 3'h5: return LWIN_5P0;
			default: return LWIN_1P5;
		endcase
	endfunction

	function automatic logic [51:0] expv();
		logic pin;
		case (sh[9][5:4])
			2'h0: pin = lock_in;
			2'h1: pin = cal_in;
			2'h2: pin = 1'b0;
			default: pin = 1'b1;
		endcase
		return {pin, win(sh[9][2:0]), sh[9][5:4], sh[9][2:0], sh[8][0], sh[7][1:0], sh[6][2:0], sh[5],
			sh[4][2:0], sh[3], sh[2][4:0], sh[1][4:0], sh[0][5:0]};
	endfunction

	// ----------------------------------------
	// Checks and bus tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [51:0] e, input logic [51:0] g);
		check_count++;
		if (g !== e)
		begin
			mismatches++;
			$display("ERROR %s expected %h got %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		u_trx_host_model.xfer(1'b0, a, d, 16, q);
		if (a >= OFS_LO_SWITCH && a <= OFS_LOCK_CFG)
			sh[a - OFS_LO_SWITCH] = d & MSK[a - OFS_LO_SWITCH];
		chk("outputs", expv(), got_v);
	endtask

	task automatic rd(input logic [6:0] a);
		logic [7:0] e;
		e = (a >= OFS_LO_SWITCH && a <= OFS_LOCK_CFG) ? sh[a - OFS_LO_SWITCH] : 8'h00;
		u_trx_host_model.xfer(1'b1, a, 8'h00, 16, q);
		chk("readback", {44'h0, e}, {44'h0, q});
	endtask

	task automatic do_reset(input int n);
		nrst = 1'b0;
		repeat (n) @(negedge mclk);
		nrst = 1'b1;
		repeat (4) @(negedge mclk);
		for (int r = 0; r < 10; r++)
			sh[r] = RSTV[r];
		chk("reset outputs", expv(), got_v);
		for (int r = 0; r < 10; r++)
			rd(OFS_LO_SWITCH + 7'(r));
	endtask

	task automatic summarize;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 45000)
		begin
			mismatches++;
			summarize();
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		logic [31:0] v;
		mclk = 1'b0;
		nrst = 1'b0;
		lock_in = 1'b0;
		cal_in = 1'b0;
		seed = 32'h1;
		mismatches = 0;
		check_count = 0;
		cycles = 0;
		do_reset(20);
		// Ones in unused bits must be dropped; limits 0 and 31 of the step words come first.
		for (int p = 0; p < 3; p++)
			for (int r = 0; r < 10; r++)
			begin
				v = xs();
				wr(OFS_LO_SWITCH + 7'(r), (p == 0) ? 8'hff : (p == 1) ? 8'h00 : v[7:0]);
				rd(OFS_LO_SWITCH + 7'(r));
			end
		for (int c = 0; c < 32; c++)
		begin
			v = xs();
			lock_in = v[0];
			cal_in = v[1];
			wr(OFS_LOCK_CFG, {2'h0, 2'(c >> 3), 1'b0, 3'(c)});
		end
		// Unmapped offsets on both sides of the bank, then a cut-short frame.
		wr(7'h19, 8'hff);
		wr(7'h24, 8'hff);
		rd(7'h24);
		rd(7'h7f);
		u_trx_host_model.xfer(1'b0, OFS_CH0_STEP, 8'h15, 12, q);
		chk("aborted frame", expv(), got_v);
		do_reset(3);
		summarize();
	end
endmodule // test_tx_lo_gain_band_config_regs

`default_nettype wire
